// File: rtl/thermal_alert_pkg.sv
/*
 * Constants shared by the thermal event and alert logic: register offsets,
 * reset values, field positions and the timer step length.
 * Assumes a 40 MHz ref_clk and a register port driven by an external
 * serial-bus front end.
 */
package thermal_alert_pkg;
    // register offsets
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h41;
    localparam logic [7:0] STATUS_TWO_ADDR = 8'h42;
    localparam logic [7:0] CHAN_CFG_ADDR = 8'h5F;
    localparam logic [7:0] CRIT_LIMIT_ADDR = 8'h6A;
    localparam logic [7:0] MASK_ONE_ADDR = 8'h74;
    localparam logic [7:0] MASK_TWO_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THREE_ADDR = 8'h78;
    localparam logic [7:0] TIMER_ADDR = 8'h79;
    localparam logic [7:0] TIMER_LIMIT_ADDR = 8'h7A;
    localparam logic [7:0] CONFIG_FOUR_ADDR = 8'h7D;
    // reset values
    localparam logic [7:0] CRIT_LIMIT_RESET = 8'hA4;
    localparam logic [7:0] TIMER_LIMIT_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // field positions
    localparam int ALERT_EN_BIT = 0;
    localparam int TIMER_EN_BIT = 1;
    localparam int OVERRIDE_BIT = 2;
    localparam int THERMAL_EVENT_LINE_OUT_EN_BIT = 3;
    localparam int SUMMARY_BIT = 7;
    localparam int FAN_FOUR_BIT = 5;
    localparam logic [6:0] STATUS_ONE_USED = 7'h76;
    // lowest critical limit codes, one per temperature format
    localparam logic [7:0] OFFSET_MIN_CODE = 8'h00;
    localparam logic [7:0] TWOS_MIN_CODE = 8'h80;
    // pin roles
    typedef enum logic [1:0] {
        ROLE_SPEED = 2'b00,
        ROLE_THERMAL = 2'b01,
        ROLE_ALERT = 2'b10,
        ROLE_GPIO = 2'b11
    } pin_role_t;
    // timer step: 22.76 ms at a 25 ns clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int TIMER_STEP_US = 22760;
    localparam int TIMER_STEP_CYCLES = (TIMER_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam logic [7:0] TIMER_FULL = 8'hFF;
endpackage

// File: rtl/level_sync.sv
/*
 * Two-flop synchroniser for one level from a pin.
 * Assumes the input is asynchronous to ref_clk; only the second flop is read.
 */
module level_sync
    import thermal_alert_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // level
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // idle level is high, matching an undriven open-drain line
    always_comb
    begin
        next_st.first = async_in;
        next_st.second = st.first;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '{first: 1'b1, second: 1'b1};
        else
            st <= next_st;
    end

    assign sync_out = st.second;
endmodule // level_sync

// File: rtl/assert_time_counter.sv
/*
 * Cumulative assertion-time counter with read clear and saturation.
 * Assumes assert_now is already synchronised and that rd_clear is a one-cycle pulse.
 */
module assert_time_counter
    import thermal_alert_pkg::*;
#(
    parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control
    input wire logic assert_now,
    input wire logic rd_clear,
    input wire logic [7:0] limit,
    // results
    output logic [7:0] value,
    output logic over
);
    localparam int PW = $clog2(STEP_CYCLES + 1);
    localparam logic [PW-1:0] LAST = PW'(STEP_CYCLES - 1);

    typedef struct packed {
        logic [7:0] count;
        logic seen;
        logic [PW-1:0] pre;
    } cnt_state_t;

    cnt_state_t st;
    cnt_state_t next_st;

    // prescaler runs only while asserted, so partial steps carry over
    always_comb
    begin
        next_st = st;
        if (rd_clear)
        begin
            next_st.count = '0;
            next_st.pre = '0;
            next_st.seen = assert_now;
        end
        else if (assert_now)
        begin
            next_st.seen = 1'b1;
            if (st.count != TIMER_FULL)
            begin
                if (st.pre == LAST)
                begin
                    next_st.pre = '0;
                    next_st.count = st.count + 8'h01;
                end
                else
                    next_st.pre = st.pre + PW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // bit 0 marks the first assertion until the count takes over
    assign value = (st.count == 8'h00) ? {7'h00, st.seen} : st.count;
    assign over = value > limit;

    property p_timer_saturates;
        @(posedge ref_clk) disable iff (!rst_n)
        (st.count == TIMER_FULL) && !rd_clear |=> st.count == TIMER_FULL;
    endproperty
    a_timer_saturates: assert property (p_timer_saturates) else $error("timer left full scale");

    property p_timer_pauses;
        @(posedge ref_clk) disable iff (!rst_n)
        !assert_now && !rd_clear |=> $stable(st.count) && $stable(st.pre);
    endproperty
    a_timer_pauses: assert property (p_timer_pauses) else $error("timer moved while idle");

    sequence s_read_while_asserted;
        rd_clear && assert_now;
    endsequence
    property p_read_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        s_read_while_asserted ##1 assert_now [*2] |-> value == 8'h01;
    endproperty
    a_read_restart: assert property (p_read_restart) else $error("read during assertion did not restart");
endmodule // assert_time_counter

// File: rtl/thermal_event_alert_logic.sv
/*
 * Alert masking, pin role selection, thermal event timer, fan override and
 * thermal output for a temperature monitor.
 * Assumes a register port from a serial-bus front end (one-cycle read and
 * write strobes), comparator sources on ref_clk, and open-drain pins
 * resolved outside from their output enables.
 */
module thermal_event_alert_logic
    import thermal_alert_pkg::*;
#(
    parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // out-of-limit sources from the measurement logic
    input wire logic [6:0] limit_one_src,
    input wire logic [7:0] limit_two_src,
    // temperature results per channel: remote one, local, remote two
    input wire logic [2:0][9:0] temp_value,
    input wire logic [2:0] temp_valid,
    input wire logic temp_offset_mode,
    // fan state and override
    input wire logic [2:0] fan_running,
    output logic [2:0] full_speed_override,
    // multi-function pin
    input wire logic multi_pin_in,
    output logic multi_pin_out,
    output logic multi_pin_oe,
    output logic speed_sense_input_four,
    output logic gpio_level,
    // dedicated alert pin
    output logic alert_out,
    output logic alert_oe
);
    typedef struct packed {
        logic [7:0] mask_one;
        logic [7:0] mask_two;
        logic [7:0] cfg_three;
        logic [1:0] cfg_four;
        logic [7:0] timer_limit;
        logic [2:0][7:0] chan_cfg;
        logic [2:0][7:0] crit_limit;
        logic [6:0] status_one;
        logic [7:0] status_two;
        logic [2:0] trip;
        logic alert;
        logic alert_oe;
        logic pin_oe;
        logic [2:0] fan_full;
        logic speed4;
        logic gpio;
        logic [7:0] rdata;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    logic pin_sync;
    logic thermal_role;
    logic thermal_low;
    logic timer_run;
    logic timer_rd;
    logic [7:0] timer_value;
    logic timer_over;
    logic rd_one;
    logic rd_two;
    logic [6:0] src_one;
    logic [7:0] src_two;
    logic [6:0] eff_mask_one;
    logic [7:0] eff_mask_two;
    logic pending;

    // the pin is asynchronous; two flops before anything reads it
    level_sync u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(multi_pin_in),
        .sync_out(pin_sync)
    );

    // role decode and active-low thermal level
    assign thermal_role = (pin_role_t'(st.cfg_four) == ROLE_THERMAL);
    assign thermal_low = thermal_role && !pin_sync;
    assign timer_run = thermal_low && st.cfg_three[TIMER_EN_BIT];
    assign timer_rd = reg_rd && (reg_addr == TIMER_ADDR);
    assign rd_one = reg_rd && (reg_addr == STATUS_ONE_ADDR);
    assign rd_two = reg_rd && (reg_addr == STATUS_TWO_ADDR);

    assert_time_counter #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .assert_now(timer_run),
        .rd_clear(timer_rd),
        .limit(st.timer_limit),
        .value(timer_value),
        .over(timer_over)
    );

    // status sources; the timer source is held off in its read cycle so the clear can land
    assign src_one = limit_one_src & STATUS_ONE_USED;
    always_comb
    begin
        src_two = {limit_two_src[7:2], |st.trip, 1'b0};
        if (thermal_role)
            src_two[FAN_FOUR_BIT] = timer_over && !timer_rd;
    end

    // mask bits lined up with status bits; processor supply mask sits at bit 0
    assign eff_mask_one = {st.mask_one[6:2], st.mask_one[0], 1'b1};
    // fan three has no mask bit of its own and reaches the alert unless the summary mask bit is set
    assign eff_mask_two = {st.mask_two[7:5], 1'b0, st.mask_two[3:1], 1'b1};
    assign pending = (|(st.status_one & ~eff_mask_one))
        || ((|(st.status_two & ~eff_mask_two)) && !st.mask_one[SUMMARY_BIT]);

    // critical-limit compare; the minimum code means the channel is off
    function automatic logic over_crit(input logic [9:0] temp, input logic [7:0] lim, input logic offset);
        logic off;
        logic hot;
        off = offset ? (lim == OFFSET_MIN_CODE) : (lim == TWOS_MIN_CODE);
        hot = offset ? (temp > {lim, 2'b00}) : ($signed(temp) > $signed({lim, 2'b00}));
        over_crit = hot && !off;
    endfunction

    // register writes, sticky status, trips and pin drive
    always_comb
    begin
        next_st = st;
        if (reg_wr)
        begin
            case (reg_addr)
                MASK_ONE_ADDR: next_st.mask_one = reg_wdata;
                MASK_TWO_ADDR: next_st.mask_two = reg_wdata;
                CONFIG_THREE_ADDR: next_st.cfg_three = reg_wdata;
                CONFIG_FOUR_ADDR: next_st.cfg_four = reg_wdata[1:0];
                TIMER_LIMIT_ADDR: next_st.timer_limit = reg_wdata;
                default: ;
            endcase
            for (int c = 0; c < 3; c++)
            begin
                if (reg_addr == CHAN_CFG_ADDR + 8'(c))
                    next_st.chan_cfg[c] = reg_wdata;
                if (reg_addr == CRIT_LIMIT_ADDR + 8'(c))
                    next_st.crit_limit[c] = reg_wdata;
            end
        end
        // a read clears only bits whose source has gone; a new event wins
        next_st.status_one = (st.status_one & ~(rd_one ? ~src_one : 7'h00)) | src_one;
        next_st.status_two = (st.status_two & ~(rd_two ? ~src_two : 8'h00)) | src_two;
        if (thermal_role && timer_rd)
            next_st.status_two[FAN_FOUR_BIT] = src_two[FAN_FOUR_BIT];
        // each channel is judged once per measurement, so a trip lasts a whole cycle
        for (int c = 0; c < 3; c++)
        begin
            if (!st.chan_cfg[c][THERMAL_EVENT_LINE_OUT_EN_BIT])
                next_st.trip[c] = 1'b0;
            else if (temp_valid[c])
                next_st.trip[c] = over_crit(temp_value[c], st.crit_limit[c], temp_offset_mode);
        end
        next_st.alert = pending;
        next_st.alert_oe = pending && st.cfg_three[ALERT_EN_BIT];
        case (pin_role_t'(st.cfg_four))
            ROLE_THERMAL: next_st.pin_oe = |st.trip;
            ROLE_ALERT: next_st.pin_oe = pending && st.cfg_three[ALERT_EN_BIT];
            ROLE_SPEED: next_st.pin_oe = 1'b0;
            ROLE_GPIO: next_st.pin_oe = 1'b0;
            default: next_st.pin_oe = 1'b0;
        endcase
        // only fans already running are pushed to full speed
        next_st.fan_full = (st.cfg_three[OVERRIDE_BIT] && thermal_low) ? fan_running : 3'h0;
        next_st.speed4 = (pin_role_t'(st.cfg_four) == ROLE_SPEED) ? pin_sync : 1'b1;
        next_st.gpio = (pin_role_t'(st.cfg_four) == ROLE_GPIO) ? pin_sync : 1'b1;
        // read data, one cycle after the strobe; unmapped offsets read zero
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                STATUS_ONE_ADDR: next_st.rdata = {|st.status_two, st.status_one};
                STATUS_TWO_ADDR: next_st.rdata = st.status_two;
                MASK_ONE_ADDR: next_st.rdata = st.mask_one;
                MASK_TWO_ADDR: next_st.rdata = st.mask_two;
                CONFIG_THREE_ADDR: next_st.rdata = st.cfg_three;
                CONFIG_FOUR_ADDR: next_st.rdata = {6'h00, st.cfg_four};
                TIMER_ADDR: next_st.rdata = timer_value;
                TIMER_LIMIT_ADDR: next_st.rdata = st.timer_limit;
                default: next_st.rdata = 8'h00;
            endcase
            for (int c = 0; c < 3; c++)
            begin
                if (reg_addr == CHAN_CFG_ADDR + 8'(c))
                    next_st.rdata = st.chan_cfg[c];
                if (reg_addr == CRIT_LIMIT_ADDR + 8'(c))
                    next_st.rdata = st.crit_limit[c];
            end
        end
    end

    // state register; every control bit has a fixed reset value
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.mask_one <= MASK_RESET;
            st.mask_two <= MASK_RESET;
            st.cfg_three <= CONFIG_RESET;
            st.timer_limit <= TIMER_LIMIT_RESET;
            st.crit_limit <= {3{CRIT_LIMIT_RESET}};
            st.speed4 <= 1'b1;
            st.gpio <= 1'b1;
        end
        else
            st <= next_st;
    end

    // outputs; both pins are open drain and only ever pull low
    assign reg_rdata = st.rdata;
    assign alert_out = 1'b0;
    assign alert_oe = st.alert_oe;
    assign multi_pin_out = 1'b0;
    assign multi_pin_oe = st.pin_oe;
    assign full_speed_override = st.fan_full;
    assign speed_sense_input_four = st.speed4;
    assign gpio_level = st.gpio;

    property p_masked_status_sets;
        @(posedge ref_clk) disable iff (!rst_n)
        limit_two_src[7] && st.mask_two[7] |=> st.status_two[7];
    endproperty
    a_masked_status_sets: assert property (p_masked_status_sets) else $error("masked source lost status");

    property p_alert_needs_enable;
        @(posedge ref_clk) disable iff (!rst_n)
        !st.cfg_three[ALERT_EN_BIT] |=> !alert_oe;
    endproperty
    a_alert_needs_enable: assert property (p_alert_needs_enable) else $error("alert driven while disabled");

    property p_summary_bit;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_one && (st.status_two != 8'h00) |=> reg_rdata[SUMMARY_BIT];
    endproperty
    a_summary_bit: assert property (p_summary_bit) else $error("summary bit missing");

    property p_sticky_status;
        @(posedge ref_clk) disable iff (!rst_n)
        st.status_two[2] && !rd_two |=> st.status_two[2];
    endproperty
    a_sticky_status: assert property (p_sticky_status) else $error("status bit dropped without read");

    property p_override_off;
        @(posedge ref_clk) disable iff (!rst_n)
        !st.cfg_three[OVERRIDE_BIT] |=> full_speed_override == 3'h0;
    endproperty
    a_override_off: assert property (p_override_off) else $error("override without enable");

    property p_trip_holds;
        @(posedge ref_clk) disable iff (!rst_n)
        !temp_valid[1] && st.chan_cfg[1][THERMAL_EVENT_LINE_OUT_EN_BIT] |=> $stable(st.trip[1]);
    endproperty
    a_trip_holds: assert property (p_trip_holds) else $error("trip changed between measurements");

    property p_timer_flag;
        @(posedge ref_clk) disable iff (!rst_n)
        thermal_role && timer_over && !timer_rd |=> st.status_two[FAN_FOUR_BIT];
    endproperty
    a_timer_flag: assert property (p_timer_flag) else $error("timer limit flag not set");

    property p_alert_follows_status;
        @(posedge ref_clk) disable iff (!rst_n)
        st.status_one[5] && !st.mask_one[5] && st.cfg_three[ALERT_EN_BIT] |=> alert_oe;
    endproperty
    a_alert_follows_status: assert property (p_alert_follows_status) else $error("alert missing");
endmodule // thermal_event_alert_logic

// File: dv/thermal_line_model.sv
/*
 * Behavioural model of the processor hot line on the multi-function pin.
 * Assumes an open-drain wire with a pull-up shared by the device and the
 * hot source.
 */
module thermal_line_model
(
    // parties pulling low
    input wire logic hot_req,
    input wire logic dut_oe,
    // resolved wire
    output logic line
);
    timeunit 1ns;
    timeprecision 100ps;
    // pull-up wins only when nobody pulls low, so a released line reads high
    assign line = (hot_req || dut_oe) ? 1'b0 : 1'b1;
endmodule // thermal_line_model

// File: dv/thermal_event_alert_logic_tb_top.sv
/*
 * Self-checking bench for the thermal event and alert logic.
 * Assumes a short timer step so that saturation fits in a short run.
 */
module thermal_event_alert_logic_tb_top
    import thermal_alert_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic reg_wr, reg_rd, hot, pin, pin_oe, aoe, spd, gpio, aout, pout;
    logic [6:0] lim1;
    logic [7:0] lim2;
    logic [2:0][9:0] temp_value;
    logic [2:0] temp_valid, fans, fso;
    logic offs;
    int failures = 0;
    int num_checks = 0;
    int bits[5] = '{7, 6, 5, 3, 2};

    thermal_event_alert_logic #(.STEP_CYCLES(STEP)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .limit_one_src(lim1), .limit_two_src(lim2),
        .temp_value(temp_value), .temp_valid(temp_valid), .temp_offset_mode(offs),
        .fan_running(fans), .full_speed_override(fso), .multi_pin_in(pin),
        .multi_pin_out(pout), .multi_pin_oe(pin_oe), .speed_sense_input_four(spd),
        .gpio_level(gpio), .alert_out(aout), .alert_oe(aoe));
    thermal_line_model u_line (.hot_req(hot), .dut_oe(pin_oe), .line(pin));

    always #12.5 ref_clk = ~ref_clk;

    // expected timer value after n asserted cycles: reads 1 until two whole steps have passed
    function automatic logic [7:0] timer_exp(int n);
        if (n == 0)
            return 8'h00;
        if (n / STEP < 2)
            return 8'h01;
        return (n / STEP > 255) ? 8'hFF : 8'(n / STEP);
    endfunction

    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // inputs change 1 ns after the edge
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // strobe dropped, then one idle cycle so no signal is set twice at once
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        v = reg_rdata;
        cyc(1);
    endtask
    task automatic hold_hot(int n);
        hot = 1'b1;
        cyc(n);
        hot = 1'b0;
        cyc(4);
    endtask
    task automatic temp(logic [9:0] t);
        temp_value[1] = t;
        temp_valid = 3'b010;
        cyc(1);
        temp_valid = 3'b000;
        cyc(3);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #300000;
        failures++;
        $display("[ERR] run time expected end seen none");
        test_done();
    end

    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, hot, lim1, lim2} = '0;
        {temp_value, temp_valid, fans} = '0;
        offs = 1'b1;
        void'($urandom(20728));
        cyc(2);
        rst_n = 1'b1;
        rd(MASK_ONE_ADDR); chk("mask one", 8'h00, v);
        rd(MASK_TWO_ADDR); chk("mask two", 8'h00, v);
        rd(CONFIG_THREE_ADDR); chk("cfg three", 8'h00, v);
        rd(TIMER_LIMIT_ADDR); chk("limit", 8'h00, v);
        rd(8'h13); chk("unmapped", 8'h00, v);
        for (int i = 0; i < 4; i++)
        begin
            logic [7:0] d;
            d = 8'($urandom) & 8'hF5;
            wr(MASK_ONE_ADDR, d);
            rd(MASK_ONE_ADDR); chk("mask one rw", d, v);
        end
        wr(MASK_ONE_ADDR, 8'h00);
        $display("registers test done");
        lim1[5] = 1'b1;
        cyc(4); chk("alert off", 8'h00, {7'h0, aoe});
        wr(CONFIG_THREE_ADDR, 8'h01);
        cyc(2); chk("alert on", 8'h01, {7'h0, aoe});
        lim1[5] = 1'b0;
        cyc(2); chk("alert held", 8'h01, {7'h0, aoe});
        rd(STATUS_ONE_ADDR); chk("status one", 8'h20, v);
        cyc(3); chk("alert cleared", 8'h00, {7'h0, aoe});
        wr(MASK_ONE_ADDR, 8'h20);
        lim1[5] = 1'b1;
        cyc(4); chk("masked alert", 8'h00, {7'h0, aoe});
        lim1[5] = 1'b0;
        rd(STATUS_ONE_ADDR); chk("masked status", 8'h20, v);
        rd(STATUS_ONE_ADDR); chk("status cleared", 8'h00, v);
        wr(MASK_ONE_ADDR, 8'h00);
        lim2[2] = 1'b1;
        cyc(3);
        lim2[2] = 1'b0;
        rd(STATUS_ONE_ADDR); chk("summary", 8'h80, v);
        rd(STATUS_TWO_ADDR); rd(STATUS_ONE_ADDR); chk("summary clr", 8'h00, v);
        foreach (bits[i])
        begin
            wr(MASK_TWO_ADDR, 8'h01 << bits[i]);
            lim2 = 8'h01 << bits[i];
            cyc(4); chk("mask two alert", 8'h00, {7'h0, aoe});
            lim2 = 8'h00;
            rd(STATUS_TWO_ADDR); chk("status two", 8'h01 << bits[i], v);
            rd(STATUS_ONE_ADDR);
        end
        $display("alert test done");
        wr(CONFIG_FOUR_ADDR, 8'h01);
        hold_hot(12);
        rd(TIMER_ADDR); chk("timer off", 8'h00, v);
        wr(MASK_TWO_ADDR, 8'h20);
        wr(CONFIG_THREE_ADDR, 8'h03);
        hold_hot(14);
        hold_hot(14);
        chk("f4p masked", 8'h00, {7'h0, aoe});
        rd(TIMER_ADDR); chk("timer sum", timer_exp(28), v);
        rd(STATUS_TWO_ADDR); chk("f4p clr", 8'h00, v);
        rd(STATUS_ONE_ADDR);
        wr(MASK_TWO_ADDR, 8'h00);
        hot = 1'b1;
        cyc(5); chk("limit zero", 8'h01, {7'h0, aoe});
        rd(TIMER_ADDR);
        rd(TIMER_ADDR); chk("read active", 8'h01, v);
        rd(STATUS_TWO_ADDR); chk("f4p again", 8'h20, v);
        hot = 1'b0;
        cyc(4);
        rd(TIMER_ADDR); rd(STATUS_TWO_ADDR); rd(STATUS_ONE_ADDR);
        wr(TIMER_LIMIT_ADDR, 8'h01);
        hold_hot(4);
        rd(STATUS_TWO_ADDR); chk("limit one low", 8'h00, v);
        hold_hot(12);
        rd(STATUS_TWO_ADDR); chk("limit one", 8'h20, v);
        rd(TIMER_ADDR); chk("timer two", timer_exp(16), v);
        rd(STATUS_TWO_ADDR); chk("f4p read clr", 8'h00, v);
        hold_hot(2100);
        rd(TIMER_ADDR); chk("saturate", 8'hFF, v);
        rd(TIMER_ADDR); chk("read clear", 8'h00, v);
        rd(STATUS_TWO_ADDR); rd(STATUS_ONE_ADDR);
        $display("timer test done");
        fans = 3'($urandom);
        wr(CONFIG_THREE_ADDR, 8'h07);
        hot = 1'b1;
        cyc(4); chk("full_speed_override", {5'h0, fans}, {5'h0, fso});
        hot = 1'b0;
        cyc(4); chk("full_speed_override end", 8'h00, {5'h0, fso});
        wr(CONFIG_THREE_ADDR, 8'h03);
        hot = 1'b1;
        cyc(4); chk("full_speed_override off", 8'h00, {5'h0, fso});
        hot = 1'b0;
        $display("override test done");
        wr(8'h60, 8'h08);
        wr(8'h6B, 8'h40);
        temp(10'h101); chk("trip", 8'h01, {7'h0, pin_oe});
        chk("pins low", 8'h00, {6'h0, aout, pout});
        cyc(20); chk("trip held", 8'h01, {7'h0, pin_oe});
        temp(10'h100); chk("trip release", 8'h00, {7'h0, pin_oe});
        wr(8'h6B, 8'h00);
        temp(10'h3FF); chk("offset off", 8'h00, {7'h0, pin_oe});
        offs = 1'b0;
        wr(8'h6B, 8'h80);
        temp(10'h1FF); chk("twos off", 8'h00, {7'h0, pin_oe});
        offs = 1'b1;
        wr(8'h6B, 8'h40);
        wr(8'h60, 8'h00);
        temp(10'h101); chk("chan off", 8'h00, {7'h0, pin_oe});
        rd(TIMER_ADDR); rd(STATUS_TWO_ADDR); rd(STATUS_ONE_ADDR);
        $display("thermal output test done");
        wr(CONFIG_FOUR_ADDR, 8'h00);
        hot = 1'b1;
        cyc(4); chk("speed role", 8'h02, {6'h0, gpio, spd});
        wr(CONFIG_FOUR_ADDR, 8'h03);
        cyc(3); chk("gpio role", 8'h01, {6'h0, gpio, spd});
        hot = 1'b0;
        wr(CONFIG_FOUR_ADDR, 8'h02);
        lim1[4] = 1'b1;
        cyc(4); chk("alert role", 8'h01, {7'h0, pin_oe});
        lim1[4] = 1'b0;
        $display("pin role test done");
        test_done();
    end
endmodule // thermal_event_alert_logic_tb_top
